// File: src/drw_data_rom_window.sv
// data rom window: maps data 40h-7Fh onto a selectable program block
`timescale 1ns/1ps
module drw_data_rom_window #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // core data-space bus
  input  wire logic [7:0]        data_addr,
  input  wire logic [DATA_W-1:0] data_wdata,
  input  wire logic              data_wr,
  input  wire logic              data_rd,
  // answer to the core, two cycles after the read
  output logic [DATA_W-1:0]      win_rdata,
  output logic                   win_rvalid,
  // program memory read port, data is taken in the same cycle prog_rd is high
  output logic [11:0]            prog_addr,
  output logic                   prog_rd,
  input  wire logic [7:0]        prog_rdata
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int ADDR_SUM = drw_pkg::DRW_OFS_W + drw_pkg::DRW_BLK_W;
  localparam int WIN_SIZE =
    int'(drw_pkg::DRW_WIN_LAST) - int'(drw_pkg::DRW_WIN_BASE) + 1;

  // the answer path and the select are byte wide and nothing else
  if (DATA_W != 8) begin : g_bad_data_w
    $error("drw: data width must be 8");
  end
  // block and offset must fill the program address exactly
  if (ADDR_SUM != drw_pkg::DRW_PADDR_W) begin : g_bad_split
    $error("drw: block and offset widths do not fill the address");
  end
  // the program port is fixed, so the address width must match it
  if ($bits(prog_addr) != drw_pkg::DRW_PADDR_W) begin : g_bad_port
    $error("drw: program port width differs from address width");
  end
  // every window location must map to one offset inside a block
  if (WIN_SIZE != (1 << drw_pkg::DRW_OFS_W)) begin : g_bad_window
    $error("drw: window size differs from block size");
  end
  // the offset is a plain slice, so the window must start aligned
  if (int'(drw_pkg::DRW_WIN_BASE) % WIN_SIZE != 0) begin : g_bad_base
    $error("drw: window base is not aligned to a block");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // loaded only tells the checks that the select holds a real value;
  // the select itself is never cleared, so it is unknown until written
  typedef struct packed {
    logic [drw_pkg::DRW_BLK_W-1:0]   blk;
    logic [drw_pkg::DRW_PADDR_W-1:0] paddr;
    logic                            prd;
    logic                            rvalid;
    logic                            pend;
    logic                            sel_rd;
    logic [7:0]                      rdata;
    logic                            loaded;
  } drw_state_t;

  drw_state_t s_q, s_d;

  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= drw_pkg::DRW_WIN_BASE) && (a <= drw_pkg::DRW_WIN_LAST);
  endfunction

  // program address of a window location under a given block number
  function automatic logic [drw_pkg::DRW_PADDR_W-1:0] prog_address(
    input logic [drw_pkg::DRW_BLK_W-1:0] blk,
    input logic [7:0]                    a
  );
    prog_address = {blk, a[drw_pkg::DRW_OFS_W-1:0]};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.prd    = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.pend   = 1'b0;
    s_d.sel_rd = 1'b0;
    if (data_wr && data_addr == drw_pkg::DRW_SEL_ADDR) begin
      // reserved bits 7:6 are dropped, only the block number is kept
      s_d.blk    = data_wdata[drw_pkg::DRW_BLK_W-1:0];
      s_d.loaded = 1'b1;
    end
    if (data_rd && in_window(data_addr)) begin
      // a select write in this same cycle is not seen yet: old block
      s_d.paddr = prog_address(s_q.blk, data_addr);
      s_d.prd   = 1'b1;
      s_d.pend  = 1'b1;
    end
    if (data_rd && data_addr == drw_pkg::DRW_SEL_ADDR) begin
      s_d.sel_rd = 1'b1;
    end
    if (s_q.pend) begin
      s_d.rdata  = prog_rdata;
      s_d.rvalid = 1'b1;
    end else if (s_q.sel_rd) begin
      s_d.rdata  = drw_pkg::DRW_SEL_READ;
      s_d.rvalid = 1'b1;
    end
    if (!rst_n) begin
      // the block select keeps its value across reset
      s_d.prd    = 1'b0;
      s_d.rvalid = 1'b0;
      s_d.pend   = 1'b0;
      s_d.sel_rd = 1'b0;
      s_d.rdata  = '0;
      s_d.paddr  = '0;
      s_d.loaded = 1'b0;
      // a select write during reset is refused, the old block stays
      s_d.blk    = s_q.blk;
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign prog_addr  = s_q.paddr;
  assign prog_rd    = s_q.prd;
  assign win_rdata  = s_q.rdata;
  assign win_rvalid = s_q.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence win_read_s;
    data_rd && in_window(data_addr);
  endsequence

  sequence sel_write_s;
    data_wr && data_addr == drw_pkg::DRW_SEL_ADDR;
  endsequence

  sequence sel_read_s;
    data_rd && data_addr == drw_pkg::DRW_SEL_ADDR;
  endsequence

  // a window read answers in two steps: the fetch, then the data
  sequence fetch_then_answer_s;
    prog_rd ##1 win_rvalid;
  endsequence

  AST_WIN_FETCH: assert property (@(posedge clk) disable iff (!rst_n)
    win_read_s |=> fetch_then_answer_s)
    else $error("window read did not fetch program memory");
  AST_ADDR_MAP: assert property (@(posedge clk) disable iff (!rst_n)
    win_read_s |=> prog_addr[drw_pkg::DRW_OFS_W-1:0]
      == $past(data_addr[drw_pkg::DRW_OFS_W-1:0]))
    else $error("window offset not mapped to low address bits");
  AST_BLK_MAP: assert property (@(posedge clk) disable iff (!rst_n)
    sel_write_s ##1 win_read_s
    |=> prog_addr == prog_address(
          $past(data_wdata[drw_pkg::DRW_BLK_W-1:0], 2), $past(data_addr)))
    else $error("block select not used as upper address");
  AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    sel_write_s |=> s_q.blk == $past(data_wdata[drw_pkg::DRW_BLK_W-1:0]))
    else $error("select write did not load the block number");
  // only a select write may move the window
  AST_SEL_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.loaded && !(data_wr && data_addr == drw_pkg::DRW_SEL_ADDR)
    |=> $stable(s_q.blk))
    else $error("selection changed without a select write");
  // reset must neither clear nor load the select
  AST_RST_KEEP: assert property (@(posedge clk)
    !rst_n && s_q.loaded |=> $stable(s_q.blk))
    else $error("selection changed across reset");
  AST_RST_QUIET: assert property (@(posedge clk)
    !rst_n |=> !prog_rd && !win_rvalid)
    else $error("fetch or answer during reset");
  AST_PRD_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    prog_rd |-> $past(data_rd && in_window(data_addr)))
    else $error("program fetch without a window read");
  AST_ANSWER_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    win_rvalid |-> $past(data_rd && (in_window(data_addr)
      || data_addr == drw_pkg::DRW_SEL_ADDR), 2))
    else $error("answer without a read two cycles before");
  // reads of ordinary data space get no answer from this block
  AST_NO_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    data_rd && !in_window(data_addr) && data_addr != drw_pkg::DRW_SEL_ADDR
    |=> ##1 !win_rvalid)
    else $error("answer to a read outside the window");
  AST_WR_NO_FETCH: assert property (@(posedge clk) disable iff (!rst_n)
    data_wr && !data_rd |=> !prog_rd)
    else $error("write into data space fetched program memory");
  // the address stands until the next window read
  AST_PADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(data_rd && in_window(data_addr)) |=> $stable(prog_addr))
    else $error("program address moved without a window read");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.pend && !s_q.sel_rd |=> $stable(win_rdata))
    else $error("answer data moved without an answer");
  AST_SEL_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    sel_read_s |=> ##1 win_rdata == drw_pkg::DRW_SEL_READ)
    else $error("select read did not return the filler byte");
  AST_NO_FETCH: assert property (@(posedge clk) disable iff (!rst_n)
    !(data_rd && in_window(data_addr)) |=> !prog_rd)
    else $error("fetch outside window read");
  AST_SEL_RD: assert property (@(posedge clk) disable iff (!rst_n)
    data_rd && data_addr == drw_pkg::DRW_SEL_ADDR && !data_wr
    |=> $stable(s_q.blk) ##1 win_rvalid)
    else $error("select read altered selection");
  AST_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    prog_rd |=> win_rdata == $past(prog_rdata))
    else $error("window data not taken from program memory");
endmodule

// File: src/drw_pkg.sv
// constants for the data rom window block
package drw_pkg;
  localparam logic [7:0] DRW_WIN_BASE  = 8'h40;
  localparam logic [7:0] DRW_WIN_LAST  = 8'h7f;
  localparam logic [7:0] DRW_SEL_ADDR  = 8'hc9;
  localparam int         DRW_OFS_W     = 6;
  localparam int         DRW_BLK_W     = 6;
  localparam int         DRW_PADDR_W   = 12;
  localparam logic [7:0] DRW_SEL_READ  = 8'h00;
endpackage

// File: tb/drw_prog_mem.sv
// program memory model for the window reads
`timescale 1ns/1ps
module drw_prog_mem (
  // clock and program port
  input  wire logic        clk,
  input  wire logic        prog_rd,
  input  wire logic [11:0] prog_addr,
  output logic [7:0]       prog_rdata
);
  logic       hold_q;
  logic [7:0] val;
  assign val = prog_addr[7:0] ^ {2'h0, prog_addr[11:6]};
  always_ff @(posedge clk) hold_q <= prog_rd;
  // outside the read slot show the inverse, never stale data
  assign prog_rdata = (prog_rd | hold_q) ? val : ~val;
endmodule

// File: tb/test_data_rom_window.sv
// self-checking bench for the data rom window
`timescale 1ns/1ps
module test_data_rom_window;
  logic        clk, rst_n, data_wr, data_rd, win_rvalid, prog_rd;
  logic [7:0]  data_addr, data_wdata, win_rdata, prog_rdata;
  logic [11:0] prog_addr;
  int          mismatches = 0, total_checks = 0, n;
  logic [13:0] rows [4] = '{14'h0040, 14'h1061, 14'h3f7f, 14'h0140};
  drw_data_rom_window DUT (.clk(clk), .rst_n(rst_n), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_wr(data_wr), .data_rd(data_rd),
    .win_rdata(win_rdata), .win_rvalid(win_rvalid), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_rdata(prog_rdata));
  drw_prog_mem mem (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [11:0] g, e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // strobes stay up until idle or the next op, so no signal is set twice in a step
  task op(input logic w, input logic [7:0] a, d);
    {data_wr, data_rd, data_addr, data_wdata} = {w, !w, a, d};
    @(posedge clk) #1;
  endtask
  task idle;
    {data_wr, data_rd} = 0;
  endtask
  task look(input logic [7:0] a, input logic [5:0] b);
    logic [11:0] e;
    e = {b, a[5:0]};
    for (n = 0; n < 4 && win_rvalid !== 1'b1; n++) @(posedge clk) #1;
    // the wait starts just after the edge that took the read, one edge before the answer
    chk(n, 1);
    chk(prog_addr, e);
    chk(win_rdata, e[7:0] ^ {2'h0, e[11:6]});
  endtask
  initial begin
    {rst_n, data_wr, data_rd, data_addr, data_wdata} = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    chk({win_rvalid, prog_rd}, 0);
    $display("reset done");
    // select write is zero-extended, reserved bits stay clear
    for (int i = 0; i < 4; i++) begin
      op(1, 8'hc9, {2'h0, rows[i][13:8]});
      op(0, rows[i][7:0], 0);
      idle;
      look(rows[i][7:0], rows[i][13:8]);
    end
    $display("block rows done");
    op(0, 8'hc9, 0);
    idle;
    @(posedge clk) #1;
    chk({win_rvalid, win_rdata}, 12'h100);
    op(0, 8'h7e, 0);
    idle;
    look(8'h7e, 6'h01);
    $display("select read done");
    op(0, 8'h80, 0);
    idle;
    repeat (3) begin
      @(posedge clk) #1;
      chk({win_rvalid, prog_rd}, 0);
    end
    $display("outside read done");
    // a reset in mid-run must leave the block select as it was
    rst_n = 0;
    repeat (2) @(posedge clk) #1;
    chk({win_rvalid, prog_rd}, 0);
    rst_n = 1;
    op(0, 8'h45, 0);
    idle;
    look(8'h45, 6'h01);
    $display("mid-run reset done");
    print_verdict;
  end
  initial begin
    #5000;
    mismatches++;
    print_verdict;
  end
endmodule
